//--- src/gposm_pkg.sv
package gposm_pkg;

  localparam int          APB_AW          = 12;
  localparam int          APB_DW          = 32;
  localparam int          RX_PORTS        = 4;
  localparam int          TX_PORTS        = 2;
  localparam int          RX_GPIOS        = 4;

  // Register indices; byte address is four times the index
  localparam logic [7:0]  CTRL_IDX        = 8'h11;
  localparam logic [7:0]  RX_EN_IDX       = 8'h0c;
  localparam logic [7:0]  TX_MAP_IDX      = 8'h20;
  localparam logic [7:0]  STATUS_IDX      = 8'h21;
  localparam logic [11:0] CTRL_ADDR       = {2'h0, CTRL_IDX, 2'h0};
  localparam logic [11:0] RX_EN_ADDR      = {2'h0, RX_EN_IDX, 2'h0};
  localparam logic [11:0] TX_MAP_ADDR     = {2'h0, TX_MAP_IDX, 2'h0};
  localparam logic [11:0] STATUS_ADDR     = {2'h0, STATUS_IDX, 2'h0};

  localparam int          SEL_MSB         = 7;
  localparam int          SEL_LSB         = 5;
  localparam int          SRC_MSB         = 4;
  localparam int          SRC_LSB         = 2;
  localparam int          VAL_BIT         = 1;
  localparam int          EN_BIT          = 0;

  localparam logic [7:0]  CTRL_RESET      = 8'h00;
  localparam logic [3:0]  RX_EN_RESET     = 4'hf;
  localparam logic [7:0]  TX_MAP_RESET    = 8'hff;

  localparam logic [2:0]  SRC_DEV         = 3'h4;
  localparam logic [2:0]  SRC_RSV         = 3'h5;

endpackage

//--- src/gposm_port_reduce.sv
`timescale 1ns/100ps
module gposm_port_reduce #(
  parameter int N = 4
) (
  input  wire logic [N-1:0] flags,
  input  wire logic [N-1:0] mask,
  output wire logic         all_o,
  output wire logic         any_o
);
  // Empty mask: AND reads one, OR reads zero
  assign all_o = &(flags | ~mask);
  assign any_o = |(flags & mask);
endmodule

//--- src/gposm_src_mux.sv
`timescale 1ns/100ps
module gposm_src_mux (
  input  wire logic [2:0]  src,
  input  wire logic [2:0]  sel,
  input  wire logic        local_level,
  input  wire logic [15:0] rx_gpio,
  input  wire logic [3:0]  rx_lock,
  input  wire logic [3:0]  rx_pass,
  input  wire logic [3:0]  rx_fv,
  input  wire logic [3:0]  rx_lv,
  input  wire logic        dev_lock_any,
  input  wire logic        dev_lock_all,
  input  wire logic        dev_pass_all,
  input  wire logic        frame_sync,
  input  wire logic [1:0]  tx_pass_all,
  input  wire logic [1:0]  tx_pass_any,
  input  wire logic [1:0]  tx_fv,
  input  wire logic [1:0]  tx_lv,
  input  wire logic [1:0]  tx_sync,
  input  wire logic [1:0]  tx_irq,
  output wire logic        level
);
  wire logic [1:0] rx_idx;
  wire logic       tx_idx;
  wire logic [3:0] rx_stat;
  wire logic       rx_level;
  wire logic [7:0] dev_vec;
  wire logic [7:0] tx_vec;

  assign rx_idx   = src[1:0];
  assign tx_idx   = src[0];
  assign rx_stat  = {rx_lv[rx_idx], rx_fv[rx_idx], rx_pass[rx_idx], rx_lock[rx_idx]};
  assign rx_level = sel[2] ? rx_stat[sel[1:0]] : rx_gpio[{rx_idx, sel[1:0]}];
  // Reserved codes read low
  assign dev_vec  = {3'h0, frame_sync, dev_pass_all, dev_lock_all, dev_lock_any, local_level};
  assign tx_vec   = {2'h0, tx_irq[tx_idx], tx_sync[tx_idx], tx_lv[tx_idx], tx_fv[tx_idx],
                     tx_pass_any[tx_idx], tx_pass_all[tx_idx]};
  assign level    = !src[2]             ? rx_level      :
                    (src == gposm_pkg::SRC_DEV) ? dev_vec[sel] :
                    (src == gposm_pkg::SRC_RSV) ? 1'b0  : tx_vec[sel];
endmodule

//--- src/gposm_top.sv
`timescale 1ns/100ps
module gposm_top (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        clk_en,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output wire logic        pready,
  output wire logic [31:0] prdata,
  output wire logic        pslverr,
  input  wire logic [15:0] rx_gpio,
  input  wire logic [3:0]  rx_lock,
  input  wire logic [3:0]  rx_pass,
  input  wire logic [3:0]  rx_frame_valid,
  input  wire logic [3:0]  rx_line_valid,
  input  wire logic        frame_sync_pulse,
  input  wire logic [1:0]  tx_frame_valid,
  input  wire logic [1:0]  tx_line_valid,
  input  wire logic [1:0]  tx_synced,
  input  wire logic [1:0]  tx_irq,
  output wire logic        pin1_out,
  output wire logic        pin1_oe_n
);
  logic [7:0]  ctrl_reg;
  logic [3:0]  rx_en_reg;
  logic [7:0]  map_reg;
  logic        pready_reg;
  logic [31:0] prdata_reg;
  logic        pslverr_reg;
  logic        out_reg;
  logic        oe_n_reg;

  wire logic        setup;
  wire logic        wr_fire;
  wire logic        hit_ctrl;
  wire logic        hit_rx_en;
  wire logic        hit_map;
  wire logic        hit_status;
  wire logic        mapped;
  wire logic [31:0] rd_mux;
  wire logic        lock_all;
  wire logic        lock_any;
  wire logic        pass_all;
  wire logic [1:0]  tx_pass_all;
  wire logic [1:0]  tx_pass_any;
  wire logic        level;
  wire logic        out_next;

  // One wait-free access: pready rises in the first access cycle
  assign setup      = psel & ~penable;
  assign wr_fire    = psel & penable & pready_reg & pwrite;
  assign hit_ctrl   = paddr == gposm_pkg::CTRL_ADDR;
  assign hit_rx_en  = paddr == gposm_pkg::RX_EN_ADDR;
  assign hit_map    = paddr == gposm_pkg::TX_MAP_ADDR;
  assign hit_status = paddr == gposm_pkg::STATUS_ADDR;
  assign mapped     = hit_ctrl | hit_rx_en | hit_map | hit_status;
  assign rd_mux     = hit_ctrl   ? {24'h0, ctrl_reg}           :
                      hit_rx_en  ? {28'h0, rx_en_reg}          :
                      hit_map    ? {24'h0, map_reg}            :
                      hit_status ? {30'h0, ~oe_n_reg, out_reg} : 32'h0;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_reg  <= 1'b0;
      prdata_reg  <= 32'h0;
      pslverr_reg <= 1'b0;
    end else if (clk_en) begin
      pready_reg  <= setup;
      prdata_reg  <= (setup & ~pwrite) ? rd_mux : 32'h0;
      pslverr_reg <= setup & ~mapped;
    end
  end

  // Unmapped or status writes are dropped
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg  <= gposm_pkg::CTRL_RESET;
      rx_en_reg <= gposm_pkg::RX_EN_RESET;
      map_reg   <= gposm_pkg::TX_MAP_RESET;
    end else if (clk_en && wr_fire) begin
      if (hit_ctrl) begin
        ctrl_reg <= pwdata[7:0];
      end
      if (hit_rx_en) begin
        rx_en_reg <= pwdata[3:0];
      end
      if (hit_map) begin
        map_reg <= pwdata[7:0];
      end
    end
  end

  gposm_port_reduce #(.N(4)) u_lock (
    .flags (rx_lock),
    .mask  (rx_en_reg),
    .all_o (lock_all),
    .any_o (lock_any)
  );

  gposm_port_reduce #(.N(4)) u_pass (
    .flags (rx_pass),
    .mask  (rx_en_reg),
    .all_o (pass_all),
    .any_o ()
  );

  gposm_port_reduce #(.N(4)) u_tx0 (
    .flags (rx_pass),
    .mask  (map_reg[3:0]),
    .all_o (tx_pass_all[0]),
    .any_o (tx_pass_any[0])
  );

  gposm_port_reduce #(.N(4)) u_tx1 (
    .flags (rx_pass),
    .mask  (map_reg[7:4]),
    .all_o (tx_pass_all[1]),
    .any_o (tx_pass_any[1])
  );

  gposm_src_mux u_mux (
    .src          (ctrl_reg[gposm_pkg::SRC_MSB:gposm_pkg::SRC_LSB]),
    .sel          (ctrl_reg[gposm_pkg::SEL_MSB:gposm_pkg::SEL_LSB]),
    .local_level  (ctrl_reg[gposm_pkg::VAL_BIT]),
    .rx_gpio      (rx_gpio),
    .rx_lock      (rx_lock),
    .rx_pass      (rx_pass),
    .rx_fv        (rx_frame_valid),
    .rx_lv        (rx_line_valid),
    .dev_lock_any (lock_any),
    .dev_lock_all (lock_all),
    .dev_pass_all (pass_all),
    .frame_sync   (frame_sync_pulse),
    .tx_pass_all  (tx_pass_all),
    .tx_pass_any  (tx_pass_any),
    .tx_fv        (tx_frame_valid),
    .tx_lv        (tx_line_valid),
    .tx_sync      (tx_synced),
    .tx_irq       (tx_irq),
    .level        (level)
  );

  // Held low when not driving so a glitch cannot leak out on enable
  assign out_next = ctrl_reg[gposm_pkg::EN_BIT] & level;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_reg  <= 1'b0;
      oe_n_reg <= 1'b1;
    end else if (clk_en) begin
      out_reg  <= out_next;
      oe_n_reg <= ~ctrl_reg[gposm_pkg::EN_BIT];
    end
  end

  assign pready    = pready_reg;
  assign prdata    = prdata_reg;
  assign pslverr   = pslverr_reg;
  assign pin1_out  = out_reg;
  assign pin1_oe_n = oe_n_reg;
endmodule

//--- test/gposm_checker.sv
`timescale 1ns/100ps
module gposm_checker (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic [31:0] prdata,
  input wire logic        pslverr,
  input wire logic [15:0] rx_gpio,
  input wire logic [3:0]  rx_lock,
  input wire logic        pin1_out,
  input wire logic        pin1_oe_n
);
  logic [7:0] sh_reg;
  wire        hit;
  wire        g_bit;
  wire        k_bit;
  assign hit = paddr inside {gposm_pkg::CTRL_ADDR, gposm_pkg::RX_EN_ADDR, gposm_pkg::TX_MAP_ADDR,
                             gposm_pkg::STATUS_ADDR};
  assign g_bit = rx_gpio[{sh_reg[3:2], sh_reg[6:5]}];
  assign k_bit = rx_lock[sh_reg[3:2]];
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn) sh_reg <= 8'h00;
    else if (psel && penable && pready && pwrite && paddr == gposm_pkg::CTRL_ADDR) sh_reg <= pwdata[7:0];
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_read_ctrl;
    pready && !pwrite && paddr == gposm_pkg::CTRL_ADDR;
  endsequence
  a_pready_after_setup: assert property (s_setup |=> pready) else $error("no answer");
  a_pready_one_cycle: assert property (pready |=> !pready) else $error("pready held");
  a_unmapped_err: assert property (pready && !hit |-> pslverr && prdata == 32'h0) else $error("bad address");
  a_ctrl_readback: assert property (s_read_ctrl |-> prdata == {24'h0, sh_reg}) else $error("ctrl");
  a_drive_on: assert property (sh_reg[0] |=> !pin1_oe_n) else $error("not driven");
  a_drive_off: assert property (!sh_reg[0] |=> pin1_oe_n && !pin1_out) else $error("driven");
  a_local_level: assert property (
    sh_reg[7:2] == 6'h04 && sh_reg[0] |=> pin1_out == $past(sh_reg[1])) else $error("local level");
  a_rx_gpio_pick: assert property (
    sh_reg[0] && !sh_reg[7] && !sh_reg[4] |=> pin1_out == $past(g_bit)) else $error("gpio");
  a_rx_lock_pick: assert property (
    sh_reg[0] && sh_reg[7:5] == 3'h4 && !sh_reg[4] |=> pin1_out == $past(k_bit)) else $error("lock");
  a_rsv_source: assert property (sh_reg[4:2] == 3'h5 |=> !pin1_out) else $error("reserved");
endmodule
bind gposm_top gposm_checker i_gposm_checker (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
  .rx_gpio(rx_gpio), .rx_lock(rx_lock), .pin1_out(pin1_out), .pin1_oe_n(pin1_oe_n));

//--- test/gposm_pin_reader.sv
`timescale 1ns/100ps
module gposm_pin_reader (
  input  wire logic pclk,
  input  wire logic pin_drv,
  input  wire logic pin_oe_n,
  output wire logic pin_seen
);
  logic last_reg;
  // Undriven pin floats: show inverse of last driven level
  assign pin_seen = pin_oe_n ? ~last_reg : pin_drv;
  always_ff @(posedge pclk) if (!pin_oe_n) last_reg <= pin_drv;
endmodule

//--- test/gposm_tb_top.sv
`timescale 1ns/100ps
module gposm_tb_top;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, pin1_out, pin1_oe_n, pin_seen, err;
  logic        frame_sync_pulse, clk_en;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [63:0] rnd;
  logic [15:0] rx_gpio;
  logic [3:0]  rx_lock, rx_pass, rx_frame_valid, rx_line_valid;
  logic [1:0]  tx_frame_valid, tx_line_valid, tx_synced, tx_irq, ep;
  int          num_errors, check_count, c, en, map;
  gposm_top i_gposm_top (.pclk, .presetn, .clk_en, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
    .prdata, .pslverr, .rx_gpio, .rx_lock, .rx_pass, .rx_frame_valid, .rx_line_valid, .frame_sync_pulse,
    .tx_frame_valid, .tx_line_valid, .tx_synced, .tx_irq, .pin1_out, .pin1_oe_n);
  gposm_pin_reader i_gposm_pin_reader (.pclk, .pin_drv(pin1_out), .pin_oe_n(pin1_oe_n), .pin_seen);
  task automatic chk(input logic [32:0] got, input logic [32:0] exp);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    // Pre-edge values: what the slave showed as this edge sampled it
    do @(posedge pclk); while (pready !== 1'b1);
    {err, rd} = {pslverr, prdata};
    {psel, penable} <= 2'b00;
  endtask
  function automatic logic [1:0] exp_pin(int c, int en, int map);
    int s, e, t, m;
    logic l;
    s = (c >> 2) & 7;
    e = c >> 5;
    t = s & 1;
    m = map >> (4 * t);
    l = 1'b0;
    if (s < 4) l = e < 4 ? rx_gpio[4*s+e] : e == 4 ? rx_lock[s] : e == 5 ? rx_pass[s] :
                   e == 6 ? rx_frame_valid[s] : rx_line_valid[s];
    else if (s == 4) case (e)
      0: l = c[1];
      1: l = |(rx_lock & en[3:0]);
      2: l = &(rx_lock | ~en[3:0]);
      3: l = &(rx_pass | ~en[3:0]);
      4: l = frame_sync_pulse;
      default: l = 1'b0;
    endcase
    else if (s > 5) case (e)
      0: l = &(rx_pass | ~m[3:0]);
      1: l = |(rx_pass & m[3:0]);
      2: l = tx_frame_valid[t];
      3: l = tx_line_valid[t];
      4: l = tx_synced[t];
      5: l = tx_irq[t];
      default: l = 1'b0;
    endcase
    return {~c[0], c[0] & l};
  endfunction
  task automatic stop_test();
    $display("checks=%0d mismatches=%0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    pclk = 0;
    forever #20 pclk = ~pclk;
  end
  initial begin
    #2000000;
    num_errors++;
    stop_test();
  end
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata, rnd} = '0;
    {rx_gpio, rx_lock, rx_pass, rx_frame_valid, rx_line_valid, frame_sync_pulse} = '0;
    {tx_frame_valid, tx_line_valid, tx_synced, tx_irq} = '0;
    clk_en = 1'b1;
    num_errors = 0;
    check_count = 0;
    void'($urandom(6572));
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    #1 chk(pin1_oe_n, 1);
    apb(0, gposm_pkg::CTRL_ADDR, 0);
    chk(rd, 0);
    apb(0, 12'h048, 0);
    chk({err, rd}, {1'b1, 32'h0});
    $display("reset test done");
    // Random codes hit every source and select pairing
    repeat (400) begin
      {en, map, c} = {$urandom, $urandom, $urandom};
      apb(1, gposm_pkg::RX_EN_ADDR, en);
      apb(1, gposm_pkg::TX_MAP_ADDR, map);
      apb(1, gposm_pkg::CTRL_ADDR, c);
      rnd = {$urandom, $urandom};
      @(posedge pclk);
      {rx_gpio, rx_lock, rx_pass, rx_frame_valid, rx_line_valid} <= rnd[31:0];
      {frame_sync_pulse, tx_frame_valid, tx_line_valid, tx_synced, tx_irq} <= rnd[40:32];
      @(posedge pclk);
      #1 ep = exp_pin(c & 255, en & 15, map & 255);
      chk({pin1_oe_n, pin1_out}, ep);
      if (!ep[1]) chk(pin_seen, ep[0]);
      apb(0, gposm_pkg::STATUS_ADDR, 0);
      chk(rd, {30'h0, ~ep[1], ep[0]});
      apb(0, gposm_pkg::CTRL_ADDR, 0);
      chk(rd, c & 255);
    end
    $display("random test done");
    // Device source, frame sync select, driven: pin must hold while clock enable is low
    apb(1, gposm_pkg::CTRL_ADDR, 32'h91);
    frame_sync_pulse <= 1'b1;
    repeat (2) @(posedge pclk);
    #1 chk(pin1_out, 1);
    @(posedge pclk);
    {clk_en, frame_sync_pulse} <= 2'b00;
    repeat (3) @(posedge pclk);
    #1 chk(pin1_out, 1);
    @(posedge pclk);
    clk_en <= 1'b1;
    repeat (2) @(posedge pclk);
    #1 chk(pin1_out, 0);
    $display("clock enable test done");
    apb(1, gposm_pkg::CTRL_ADDR, 32'h13);
    presetn <= 1'b0;
    @(posedge pclk);
    presetn <= 1'b1;
    apb(0, gposm_pkg::CTRL_ADDR, 0);
    chk({pin1_oe_n, rd}, {1'b1, 32'h0});
    $display("second reset test done");
    stop_test();
  end
endmodule
